// ===== inc/abr_pkg.sv
// Shared constants, encodings and helpers of the asynchronous bus block.
// Assumes a single 10 MHz core clock on both ends of the bus.
package abr_pkg;
   // Bus widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int FCC_W  = 3;
   // Cycle class codes
   localparam logic [2:0] FCC_USER_DATA = 3'h1;
   localparam logic [2:0] FCC_USER_PROG = 3'h2;
   localparam logic [2:0] FCC_SUP_DATA  = 3'h5;
   localparam logic [2:0] FCC_SUP_PROG  = 3'h6;
   localparam logic [2:0] FCC_INT_ACK   = 3'h7;
   // Timing
   localparam int CLK_NS        = 100;
   localparam int GRANT_NEG_NS  = 200;
   localparam int GRANT_NEG_CYC = (GRANT_NEG_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_STAGES   = 2;
   // Reset values
   localparam logic RST_STROBE = 1'b0;
   localparam logic RST_READ   = 1'b1;
   localparam logic RST_DRIVE  = 1'b1;
   // Test-and-set modification and slave memory size
   localparam logic [7:0] TAS_SET_MASK = 8'h80;
   localparam int         SLV_WORDS    = 16;
   localparam int         SLV_IDX_W    = 4;

   // Commands of the master user port
   typedef enum logic [1:0] {
      CMD_WORD_WR = 2'h0,
      CMD_BYTE_WR = 2'h1,
      CMD_TAS     = 2'h2,
      CMD_BAD     = 2'h3
   } abr_cmd_t;

   // Bus cycle sequencer states
   typedef enum logic [5:0] {
      B_IDLE = 6'h01,
      B_ADDR = 6'h02,
      B_STRB = 6'h04,
      B_MOD  = 6'h08,
      B_WDAT = 6'h10,
      B_END  = 6'h20
   } abr_bst_t;

   // Arbitration states
   typedef enum logic [2:0] {
      A_IDLE  = 3'h1,
      A_GRANT = 3'h2,
      A_OWNED = 3'h4
   } abr_ast_t;

   // True for a cycle class code that is not reserved
   function automatic logic fcc_legal(input logic [2:0] c);
      fcc_legal = (c == FCC_USER_DATA) || (c == FCC_USER_PROG) || (c == FCC_SUP_DATA)
                  || (c == FCC_SUP_PROG) || (c == FCC_INT_ACK);
   endfunction : fcc_legal

   // Byte written back by test-and-set
   function automatic logic [7:0] tas_modify(input logic [7:0] b);
      tas_modify = b | TAS_SET_MASK;
   endfunction : tas_modify
endpackage : abr_pkg

// ===== inc/abr_bus_if.sv
// Shared bus between the processor end and the peer end.
// Signals are positive logic; the interface resolves wire levels from enables.
`timescale 1ns/1ps
interface abr_bus_if;
   // Processor drive
   logic                        cpu_ctl_oe;
   logic                        cpu_as;
   logic                        cpu_uds;
   logic                        cpu_lds;
   logic                        cpu_rd;
   logic [abr_pkg::ADDR_W-1:1]  cpu_addr;
   logic [abr_pkg::FCC_W-1:0]   cpu_fcc;
   logic [abr_pkg::DATA_W-1:0]  cpu_data;
   logic                        cpu_data_oe;
   logic                        cpu_grant;
   // Peer drive
   logic                        peer_ack;
   logic [abr_pkg::DATA_W-1:0]  peer_data;
   logic                        peer_data_oe;
   logic                        peer_req_oe;
   logic                        peer_taken_oe;
   // Resolved wires
   logic                        addr_strobe;
   logic                        upper_byte_strobe;
   logic                        lower_byte_strobe;
   logic                        read_dir;
   logic [abr_pkg::ADDR_W-1:1]  addr;
   logic [abr_pkg::FCC_W-1:0]   cycle_class_code;
   logic [abr_pkg::DATA_W-1:0]  data;
   logic                        transfer_ack;
   logic                        mastership_request;
   logic                        mastership_grant;
   logic                        mastership_taken;

   // Released lines read as inactive
   assign addr_strobe        = cpu_ctl_oe & cpu_as;
   assign upper_byte_strobe  = cpu_ctl_oe & cpu_uds;
   assign lower_byte_strobe  = cpu_ctl_oe & cpu_lds;
   assign read_dir           = cpu_ctl_oe ? cpu_rd : 1'b1;
   assign addr               = cpu_ctl_oe ? cpu_addr : '0;
   assign cycle_class_code   = cpu_ctl_oe ? cpu_fcc : '0;
   assign data               = cpu_data_oe ? cpu_data : (peer_data_oe ? peer_data : '0);
   assign transfer_ack       = peer_ack;
   assign mastership_request = peer_req_oe;
   assign mastership_grant   = cpu_grant;
   assign mastership_taken   = peer_taken_oe;

   modport cpu (
      output cpu_ctl_oe, cpu_as, cpu_uds, cpu_lds, cpu_rd, cpu_addr, cpu_fcc,
             cpu_data, cpu_data_oe, cpu_grant,
      input  data, transfer_ack, mastership_request, mastership_taken
   );
   modport peer (
      output peer_ack, peer_data, peer_data_oe, peer_req_oe, peer_taken_oe,
      input  addr_strobe, upper_byte_strobe, lower_byte_strobe, read_dir, addr,
             cycle_class_code, data, mastership_grant, mastership_taken
   );
endinterface : abr_bus_if

// ===== design/abr_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Only the second stage may be read by other logic.
`timescale 1ns/1ps
module abr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // Levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // Two flops, one cycle of settling
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : abr_sync

// ===== design/abr_cpu_end.sv
// Processor end: write, byte write and test-and-set cycles plus arbitration.
// Assumes the peer end keeps the slave and requesting-master duties.
//
// How it works
// [RULE_01] Byte write: upper strobe if select zero
// [RULE_02] Word write asserts both byte strobes together
// [RULE_03] Address strobe held through whole RMW cycle
// [RULE_04] RMW only from test-and-set, single byte
// [RULE_05] RMW read: read, code, address, strobes, latch
// [RULE_06] RMW write: data, strobe, then release in order
// [RULE_07] Slave decodes, answers, then drops on strobes
// [RULE_08] Wired-OR request; finish started cycle first
// [RULE_09] Request gone before taken: withdraw grant
// [RULE_10] Grant after sync, delayed past committed cycle
// [RULE_11] Requester waits strobe, ack, taken negated
// [RULE_12] Taken holder owns bus until release
// [RULE_13] Granted master drops request; regrant pending
// [RULE_14] No bus cycle between grant and regrant
// [RULE_15] Inputs synchronised within two clock cycles
// [RULE_16] Arbiter acts on edge after synced input
// [RULE_17] Three-state releases bus once strobe negated
// [RULE_18] Arbiter holds while bus in first states
// [RULE_19] Request during committed cycle: grant second edge
// [RULE_20] Grant negated few cycles after taken
// [RULE_21] Drive legal cycle class code with strobe
// [RULE_22] Stay off the bus while taken held
`timescale 1ns/1ps
module abr_cpu_end (
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   // Bus
   abr_bus_if.cpu                          bus,
   // Command request
   input  wire logic                       cmd_valid,
   input  wire abr_pkg::abr_cmd_t          cmd_kind,
   input  wire logic [abr_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [abr_pkg::DATA_W-1:0] cmd_wdata,
   input  wire logic [abr_pkg::FCC_W-1:0]  cmd_class,
   output logic                            cmd_ready,
   // Command answer
   output logic                            cmd_done,
   output logic                            cmd_err,
   output logic [7:0]                      tas_rdata,
   // Status
   output logic                            bus_released
);
   abr_pkg::abr_bst_t          bst_q;
   abr_pkg::abr_ast_t          ast_q;
   logic                       req_s;
   logic                       taken_s;
   logic                       ack_s;
   logic                       is_tas_q;
   logic                       is_word_q;
   logic                       sel_q;
   logic                       rmw_wr_q;
   logic [abr_pkg::DATA_W-1:0] wdata_q;
   logic [7:0]                 cnt_q;
   logic                       tri_q;
   logic                       hold_arb;
   logic                       accept;

   // Request, taken and ack synchronised
   abr_sync #(.W(3)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in ({bus.mastership_request, bus.mastership_taken, bus.transfer_ack}),
      .sync_out ({req_s, taken_s, ack_s})
   ); // RULE_15

   // Arbiter frozen while cycle committed without strobe
   assign hold_arb = (bst_q == abr_pkg::B_ADDR) || accept; // RULE_18
   assign accept   = cmd_valid && cmd_ready && (bst_q == abr_pkg::B_IDLE);

   // Ready only while nobody else wants or holds the bus
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ready <= 1'b0;
      end else begin
         cmd_ready <= (bst_q == abr_pkg::B_IDLE) && !accept && (ast_q == abr_pkg::A_IDLE)
                      && !req_s && !taken_s && !bus.cpu_grant; // RULE_14 RULE_22
      end
   end

   // Bus cycle sequencer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bst_q     <= abr_pkg::B_IDLE;
         is_tas_q  <= 1'b0;
         is_word_q <= 1'b0;
         sel_q     <= 1'b0;
         rmw_wr_q  <= 1'b0;
         wdata_q   <= '0;
         cmd_done  <= 1'b0;
         cmd_err   <= 1'b0;
         tas_rdata <= '0;
      end else begin
         cmd_done <= 1'b0;
         cmd_err  <= 1'b0;
         unique case (bst_q)
            abr_pkg::B_IDLE: begin
               if (accept) begin
                  if (abr_pkg::fcc_legal(cmd_class) && cmd_kind != abr_pkg::CMD_BAD) begin
                     bst_q     <= abr_pkg::B_ADDR;
                     is_tas_q  <= (cmd_kind == abr_pkg::CMD_TAS); // RULE_04
                     is_word_q <= (cmd_kind == abr_pkg::CMD_WORD_WR);
                     sel_q     <= cmd_addr[0];
                     rmw_wr_q  <= 1'b0;
                     wdata_q   <= (cmd_kind == abr_pkg::CMD_WORD_WR) ? cmd_wdata
                                  : {cmd_wdata[7:0], cmd_wdata[7:0]};
                  end else begin
                     cmd_err <= 1'b1; // RULE_21
                  end
               end
            end
            abr_pkg::B_ADDR: begin
               bst_q <= abr_pkg::B_STRB;
            end
            abr_pkg::B_STRB: begin
               if (ack_s) begin
                  if (is_tas_q && !rmw_wr_q) begin
                     // Latch the read byte from its lane
                     tas_rdata <= sel_q ? bus.data[7:0] : bus.data[15:8]; // RULE_05
                     bst_q     <= abr_pkg::B_MOD;
                  end else begin
                     bst_q <= abr_pkg::B_END;
                  end
               end
            end
            abr_pkg::B_MOD: begin
               if (!ack_s) begin
                  wdata_q <= {abr_pkg::tas_modify(tas_rdata), abr_pkg::tas_modify(tas_rdata)};
                  bst_q   <= abr_pkg::B_WDAT;
               end
            end
            abr_pkg::B_WDAT: begin
               rmw_wr_q <= 1'b1;
               bst_q    <= abr_pkg::B_STRB;
            end
            abr_pkg::B_END: begin
               if (!ack_s) begin
                  cmd_done <= 1'b1;
                  bst_q    <= abr_pkg::B_IDLE;
               end
            end
         endcase
      end
   end

   // Address, class code, strobes and direction
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.cpu_as   <= abr_pkg::RST_STROBE;
         bus.cpu_uds  <= abr_pkg::RST_STROBE;
         bus.cpu_lds  <= abr_pkg::RST_STROBE;
         bus.cpu_rd   <= abr_pkg::RST_READ;
         bus.cpu_addr <= '0;
         bus.cpu_fcc  <= '0;
      end else begin
         if (accept) begin
            bus.cpu_addr <= cmd_addr[abr_pkg::ADDR_W-1:1];
            bus.cpu_fcc  <= cmd_class; // RULE_21
            bus.cpu_rd   <= (cmd_kind == abr_pkg::CMD_TAS); // RULE_05
         end
         unique case (bst_q)
            abr_pkg::B_ADDR, abr_pkg::B_WDAT: begin
               bus.cpu_as  <= 1'b1;
               bus.cpu_uds <= is_word_q || !sel_q; // RULE_01 RULE_02
               bus.cpu_lds <= is_word_q || sel_q; // RULE_01 RULE_02
            end
            abr_pkg::B_STRB: begin
               if (ack_s) begin
                  bus.cpu_uds <= 1'b0;
                  bus.cpu_lds <= 1'b0;
                  // Strobe stays on between the two RMW phases
                  bus.cpu_as  <= is_tas_q && !rmw_wr_q; // RULE_03
               end
            end
            abr_pkg::B_MOD: begin
               if (!ack_s) begin
                  bus.cpu_rd <= 1'b0; // RULE_06
               end
            end
            abr_pkg::B_END: begin
               bus.cpu_rd <= 1'b1; // RULE_06
            end
            abr_pkg::B_IDLE: begin
            end
         endcase
      end
   end

   // Write data drive
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.cpu_data    <= '0;
         bus.cpu_data_oe <= 1'b0;
      end else begin
         if ((bst_q == abr_pkg::B_ADDR && !is_tas_q) || bst_q == abr_pkg::B_WDAT) begin
            bus.cpu_data    <= wdata_q;
            bus.cpu_data_oe <= 1'b1; // RULE_06
         end else if (bst_q == abr_pkg::B_END) begin
            bus.cpu_data_oe <= 1'b0; // RULE_06
         end
      end
   end

   // Arbitration state machine
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ast_q         <= abr_pkg::A_IDLE;
         bus.cpu_grant <= 1'b0;
         cnt_q         <= '0;
         tri_q         <= 1'b0;
      end else if (!hold_arb) begin // RULE_18 RULE_19 RULE_10
         unique case (ast_q)
            abr_pkg::A_IDLE: begin
               if (req_s) begin
                  bus.cpu_grant <= 1'b1; // RULE_10 RULE_16 RULE_08
                  ast_q         <= abr_pkg::A_GRANT;
               end
            end
            abr_pkg::A_GRANT: begin
               if (taken_s) begin
                  tri_q <= 1'b1; // RULE_17
                  cnt_q <= 8'(abr_pkg::GRANT_NEG_CYC);
                  ast_q <= abr_pkg::A_OWNED;
               end else if (!req_s) begin
                  bus.cpu_grant <= 1'b0; // RULE_09
                  tri_q         <= 1'b0;
                  ast_q         <= abr_pkg::A_IDLE;
               end
            end
            abr_pkg::A_OWNED: begin
               if (cnt_q != 8'h00) begin
                  cnt_q <= cnt_q - 8'h01;
                  if (cnt_q == 8'h01) begin
                     bus.cpu_grant <= 1'b0; // RULE_20
                  end
               end else if (!bus.cpu_grant && req_s) begin
                  bus.cpu_grant <= 1'b1; // RULE_13
               end
               if (!taken_s) begin
                  tri_q <= 1'b0; // RULE_12
                  ast_q <= (bus.cpu_grant && cnt_q == 8'h00) ? abr_pkg::A_GRANT
                           : abr_pkg::A_IDLE;
                  if (!bus.cpu_grant || cnt_q != 8'h00) begin
                     bus.cpu_grant <= 1'b0; // RULE_20
                  end
               end
            end
         endcase
      end
   end

   // Release of address, control and class lines
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.cpu_ctl_oe <= abr_pkg::RST_DRIVE;
         bus_released   <= 1'b0;
      end else begin
         bus.cpu_ctl_oe <= !((tri_q || taken_s) && !bus.cpu_as); // RULE_17 RULE_22
         bus_released   <= (tri_q || taken_s) && !bus.cpu_as;
      end
   end
endmodule : abr_cpu_end

// ===== design/abr_peer_end.sv
// Peer end: byte-lane slave memory and an external requesting master.
// Assumes the processor end drives the strobes and the grant.
`timescale 1ns/1ps
module abr_peer_end (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Bus
   abr_bus_if.peer   bus,
   // Master user side
   input  wire logic want_bus,
   input  wire logic keep_bus,
   output logic      owns_bus,
   // Slave status
   output logic      served
);
   logic [abr_pkg::DATA_W-1:0] mem_q [abr_pkg::SLV_WORDS];
   logic [abr_pkg::SLV_IDX_W-1:0] idx;
   logic                          any_strb;

   assign idx      = bus.addr[abr_pkg::SLV_IDX_W:1];
   assign any_strb = bus.upper_byte_strobe || bus.lower_byte_strobe;

   // Slave answer and release on strobe negation
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.peer_ack     <= 1'b0;
         bus.peer_data    <= '0;
         bus.peer_data_oe <= 1'b0;
         served           <= 1'b0;
      end else begin
         served <= 1'b0;
         if (bus.addr_strobe && any_strb && !bus.peer_ack) begin
            bus.peer_ack     <= 1'b1; // RULE_07
            served           <= 1'b1;
            bus.peer_data    <= mem_q[idx];
            bus.peer_data_oe <= bus.read_dir;
         end else if (!any_strb) begin
            bus.peer_ack     <= 1'b0; // RULE_07
            bus.peer_data_oe <= 1'b0;
         end
      end
   end

   // Lane writes into slave storage
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < abr_pkg::SLV_WORDS; i++) begin
            mem_q[i] <= '0;
         end
      end else if (bus.addr_strobe && any_strb && !bus.peer_ack && !bus.read_dir) begin
         if (bus.upper_byte_strobe) begin
            mem_q[idx][15:8] <= bus.data[15:8];
         end
         if (bus.lower_byte_strobe) begin
            mem_q[idx][7:0] <= bus.data[7:0];
         end
      end
   end

   // Requesting master
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.peer_req_oe   <= 1'b0;
         bus.peer_taken_oe <= 1'b0;
         owns_bus          <= 1'b0;
      end else begin
         if (want_bus && !bus.peer_req_oe && !bus.peer_taken_oe) begin
            bus.peer_req_oe <= 1'b1; // RULE_08
         end
         if (bus.peer_req_oe && bus.mastership_grant && !bus.addr_strobe
             && !bus.peer_ack && !bus.mastership_taken) begin
            bus.peer_taken_oe <= 1'b1; // RULE_11
            bus.peer_req_oe   <= 1'b0; // RULE_13
            owns_bus          <= 1'b1;
         end else if (bus.peer_taken_oe && !keep_bus) begin
            bus.peer_taken_oe <= 1'b0; // RULE_12
            owns_bus          <= 1'b0;
         end
      end
   end
endmodule : abr_peer_end

// ===== tb/abr_bus_properties.sv
// Concurrent checks on the resolved lines of the shared bus.
// Assumes one core clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module abr_bus_properties (
   // Clock and reset
   input wire logic                      core_clk,
   input wire logic                      rst_n,
   // Processor lines
   input wire logic                      addr_strobe,
   input wire logic                      upper_byte_strobe,
   input wire logic                      lower_byte_strobe,
   input wire logic                      read_dir,
   input wire logic [abr_pkg::FCC_W-1:0] cycle_class_code,
   input wire logic                      cpu_ctl_oe,
   input wire logic                      cpu_data_oe,
   // Handshake and arbitration lines
   input wire logic                      transfer_ack,
   input wire logic                      mastership_request,
   input wire logic                      mastership_grant,
   input wire logic                      mastership_taken
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Strobes only inside an address strobe, with a legal class code
   a_strobe_in_as: assert property ((upper_byte_strobe || lower_byte_strobe) |-> addr_strobe)
      else $error("byte strobe outside address strobe");
   a_class_legal: assert property (addr_strobe |-> cycle_class_code inside {1, 2, 5, 6, 7})
      else $error("reserved cycle class code");
   // Address strobe drops together with or after the byte strobes
   a_as_after_strobe: assert property ($fell(addr_strobe) |-> !upper_byte_strobe && !lower_byte_strobe)
      else $error("address strobe dropped before byte strobe");
   // Read phase of a locked cycle runs into the write-back
   a_rmw_as_held: assert property ($fell(upper_byte_strobe || lower_byte_strobe) && addr_strobe && read_dir
      |-> addr_strobe throughout (##[1:12] (!read_dir && (upper_byte_strobe || lower_byte_strobe))))
      else $error("locked cycle lost its address strobe");
   // Slave answers only a live strobe
   a_ack_on_strobe: assert property ($rose(transfer_ack) |-> upper_byte_strobe || lower_byte_strobe)
      else $error("acknowledge without strobe");
   // Grant follows the synchronised request
   a_grant_after_sync: assert property ($rose(mastership_request)
      |-> !mastership_grant [*3] ##[1:3] mastership_grant)
      else $error("grant not on time after request");
   a_grant_cause: assert property ($rose(mastership_grant) |-> $past(mastership_request, 2))
      else $error("grant without synchronised request");
   // Grant withdrawn when nobody asks or holds, and within five cycles after taken rises
   a_grant_withdrawn: assert property ((!mastership_request && !mastership_taken) [*4]
      |-> !mastership_grant)
      else $error("grant kept with no request");
   a_grant_drops: assert property ($rose(mastership_taken) |-> ##[1:5] !mastership_grant)
      else $error("grant not negated after taken");
   // Requester takes the bus only when it is free
   a_take_when_free: assert property ($rose(mastership_taken)
      |-> $past(!addr_strobe && !transfer_ack && mastership_grant))
      else $error("mastership taken on busy bus");
   // Processor stays off a bus that another master holds
   a_off_while_taken: assert property (mastership_taken
      |-> !addr_strobe && !upper_byte_strobe && !lower_byte_strobe)
      else $error("processor cycle while bus taken");
   a_released: assert property (mastership_taken [*4] |-> !cpu_ctl_oe && !cpu_data_oe)
      else $error("lines not released while taken");
   a_no_cycle_regrant: assert property ($fell(mastership_grant) |-> !addr_strobe [*2])
      else $error("bus cycle between grants");
endmodule : abr_bus_properties

// ===== tb/tb_async_bus_write_rmw_arbitration.sv
// Self-checking bench: processor end and peer end joined by the shared bus.
// Assumes package and interface compiled first; one 10 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
   $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module tb_async_bus_write_rmw_arbitration;
   logic                       core_clk;
   logic                       rst_n;
   logic                       cmd_valid;
   abr_pkg::abr_cmd_t          cmd_kind;
   logic [abr_pkg::ADDR_W-1:0] cmd_addr;
   logic [abr_pkg::DATA_W-1:0] cmd_wdata;
   logic [abr_pkg::FCC_W-1:0]  cmd_class;
   logic                       cmd_ready;
   logic                       cmd_done;
   logic                       cmd_err;
   logic [7:0]                 tas_rdata;
   logic                       bus_released;
   logic                       want_bus;
   logic                       keep_bus;
   logic                       owns_bus;
   int                         errors;
   int                         comparisons;
   logic [15:0]                mem [16];
   logic [2:0]                 lg [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};

   abr_bus_if bus ();
   abr_cpu_end abr_cpu_end_i (.core_clk(core_clk), .rst_n(rst_n), .bus(bus),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_class(cmd_class), .cmd_ready(cmd_ready),
      .cmd_done(cmd_done), .cmd_err(cmd_err), .tas_rdata(tas_rdata),
      .bus_released(bus_released));
   abr_peer_end abr_peer_end_i (.core_clk(core_clk), .rst_n(rst_n), .bus(bus),
      .want_bus(want_bus), .keep_bus(keep_bus), .owns_bus(owns_bus), .served());
   abr_bus_properties abr_bus_properties_i (.core_clk(core_clk), .rst_n(rst_n),
      .addr_strobe(bus.addr_strobe), .upper_byte_strobe(bus.upper_byte_strobe),
      .lower_byte_strobe(bus.lower_byte_strobe), .read_dir(bus.read_dir),
      .cycle_class_code(bus.cycle_class_code), .cpu_ctl_oe(bus.cpu_ctl_oe),
      .cpu_data_oe(bus.cpu_data_oe), .transfer_ack(bus.transfer_ack),
      .mastership_request(bus.mastership_request),
      .mastership_grant(bus.mastership_grant), .mastership_taken(bus.mastership_taken));

   // Clock
   initial core_clk = 1'b0;
   always #(abr_pkg::CLK_NS / 2) core_clk = ~core_clk;

   // Verdict and end of run
   task automatic conclude();
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   // Step to just after the next rising edge
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask : tick

   // Bounded wait for the peer's ownership level
   task automatic wait_own(input logic v);
      int n;
      n = 0;
      while (owns_bus !== v) begin
         if (n > 80) begin
            errors++;
            conclude();
         end
         n++;
         tick();
      end
   endtask : wait_own

   // One command with its expected outcome from the byte-lane model
   task automatic op(input logic [1:0] k, input logic [23:0] a, input logic [15:0] wd,
                     input logic [2:0] c);
      int         n;
      logic       r;
      logic       bad;
      logic [1:0] seen;
      logic [3:0] i;
      logic [7:0] b;
      i = a[4:1];
      bad = (k == 2'h3) || !(c inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7});
      seen = 2'h0;
      cmd_kind = abr_pkg::abr_cmd_t'(k);
      cmd_addr = a;
      cmd_wdata = wd;
      cmd_class = c;
      cmd_valid = 1'b1;
      n = 0;
      r = 1'b0;
      while (r !== 1'b1) begin
         r = cmd_ready;
         tick();
         n++;
         if (n > 300) begin
            errors++;
            conclude();
         end
      end
      cmd_valid = 1'b0;
      n = 0;
      while (cmd_done !== 1'b1 && cmd_err !== 1'b1) begin
         tick();
         seen = seen | {bus.upper_byte_strobe, bus.lower_byte_strobe};
         n++;
         if (n > 300) begin
            errors++;
            conclude();
         end
      end
      `CHK("cmd_err", bad, cmd_err);
      if (bad) begin
         `CHK("no strobes", 2'h0, seen);
      end else begin
         `CHK("strobes", (k == 2'h0) ? 2'h3 : (a[0] ? 2'h1 : 2'h2), seen);
         b = a[0] ? mem[i][7:0] : mem[i][15:8];
         if (k == 2'h2) begin
            `CHK("tas_rdata", b, tas_rdata);
            b = b | 8'h80;
         end else begin
            b = wd[7:0];
         end
         if (k == 2'h0) mem[i] = wd;
         else if (a[0]) mem[i][7:0] = b;
         else mem[i][15:8] = b;
      end
   endtask : op

   // Another master takes the bus, gets it again while still asking
   task automatic arb();
      want_bus = 1'b1;
      keep_bus = 1'b1;
      wait_own(1'b1);
      repeat (6) tick();
      `CHK("bus_released", 1'b1, bus_released);
      `CHK("cmd_ready", 1'b0, cmd_ready);
      `CHK("grant", 1'b0, bus.mastership_grant);
      keep_bus = 1'b0;
      wait_own(1'b0);
      wait_own(1'b1);
      want_bus = 1'b0;
      wait_own(1'b0);
      repeat (6) tick();
      `CHK("bus back", 1'b0, bus_released);
   endtask : arb

   // Main sequence
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_kind = abr_pkg::CMD_WORD_WR;
      cmd_addr = '0;
      cmd_wdata = '0;
      cmd_class = 3'h1;
      want_bus = 1'b0;
      keep_bus = 1'b0;
      errors = 0;
      comparisons = 0;
      foreach (mem[j]) mem[j] = 16'h0000;
      void'($urandom(81));
      repeat (8) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      tick();
      // Every class code, then an illegal kind
      for (int c = 0; c < 8; c++) op(2'h0, 24'h000004, 16'hA55A + 16'(c), 3'(c));
      op(2'h3, 24'h000006, 16'h1234, 3'h5);
      // Random word and byte writes
      for (int n = 0; n < 24; n++) begin
         op(2'($urandom_range(1, 0)), 24'($urandom), 16'($urandom), lg[$urandom_range(4, 0)]);
      end
      // Test-and-set over every byte, then once more on a set byte
      for (int j = 0; j < 32; j++) op(2'h2, 24'(j), 16'h0000, 3'h5);
      op(2'h2, 24'h000003, 16'h0000, 3'h1);
      // Arbitration on an idle bus, then during a cycle
      arb();
      fork
         arb();
         begin
            tick();
            tick();
            op(2'h1, 24'h000009, 16'h00C3, 3'h1);
         end
      join
      op(2'h2, 24'h000009, 16'h0000, 3'h6);
      conclude();
   end
endmodule : tb_async_bus_write_rmw_arbitration
